// >>> rtl/fcsu_pkg.sv
// fcsu_pkg: constants shared by the flash command host controller.
// assumes a 200 MHz clock and a byte-wide flash with a command latch.
package fcsu_pkg;
  // clock and pin timing
  localparam int CLK_MHZ = 200;
  localparam int STROBE_NS = 100;
  localparam int STROBE_CYC = (STROBE_NS * CLK_MHZ + 999) / 1000;
  localparam int RECOVER_NS = 50;
  localparam int RECOVER_CYC = (RECOVER_NS * CLK_MHZ + 999) / 1000;
  localparam logic [7:0] STROBE_CNT = 8'(STROBE_CYC);
  localparam logic [7:0] RECOVER_CNT = 8'(RECOVER_CYC);
  // flash command bytes
  localparam logic [7:0] CMD_READ_ARRAY = 8'hff;
  localparam logic [7:0] CMD_IDENT = 8'h90;
  localparam logic [7:0] CMD_READ_STATUS = 8'h70;
  localparam logic [7:0] CMD_CLEAR_STATUS = 8'h50;
  localparam logic [7:0] CMD_ERASE_SETUP = 8'h20;
  localparam logic [7:0] CMD_CONFIRM = 8'hd0;
  localparam logic [7:0] CMD_SUSPEND = 8'hb0;
  localparam logic [7:0] CMD_PROG_SETUP = 8'h40;
  // status byte fields
  localparam int SR_READY = 7;
  localparam int SR_SUSP = 6;
  localparam int SR_ERASE_ERR = 5;
  localparam int SR_PROG_ERR = 4;
  localparam int SR_SUPPLY_LOW = 3;
  localparam logic [7:0] SR_USED_MASK = 8'hf8;
  localparam logic [7:0] SR_RESET_VAL = 8'h80;
  // identifier offsets
  localparam logic [16:0] ID_MFR_ADDR = 17'h00000;
  localparam logic [16:0] ID_DEV_ADDR = 17'h00001;
  // axi register offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0c;
  localparam logic [7:0] REG_RDATA = 8'h10;
  localparam logic [7:0] REG_FLASH_SR = 8'h14;
  // ctrl register op codes (bits 3:0), bit 8 = go
  localparam int CTRL_GO = 8;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;
  typedef enum logic [3:0] {
    OP_READ_ARRAY, OP_IDENT, OP_READ_STATUS, OP_CLEAR_STATUS,
    OP_ERASE, OP_SUSPEND, OP_RESUME, OP_PROGRAM, OP_READ, OP_POWERDOWN,
    OP_WAKE
  } fcsu_op_t;
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage : fcsu_pkg

// >>> rtl/fcsu_sync.sv
// fcsu_sync: two-flip-flop synchroniser for one bus of pin inputs.
// assumes inputs arrive from outside ref_clk_i; first stage feeds only
// the second.
module fcsu_sync #(
  parameter int W = 8
) (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // pins and synchronised copy
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } fcsu_sync_t;
  fcsu_sync_t st_r;
  fcsu_sync_t st_nxt;

  // shift one stage per edge
  always_comb begin
    st_nxt = st_r;
    st_nxt.s1 = d_i;
    st_nxt.s2 = st_r.s1;
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.s2;
endmodule : fcsu_sync

// >>> rtl/fcsu_axil.sv
// fcsu_axil: axi4-lite slave holding the controller's own registers.
// assumes one outstanding write and one outstanding read from the master.
module fcsu_axil
  import fcsu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // axi write
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi read
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // core side
  output logic [3:0] op_o,
  output logic go_o,
  output logic [16:0] addr_o,
  output logic [7:0] data_o,
  input wire logic busy_i,
  input wire logic refused_i,
  input wire logic [7:0] rdata_i,
  input wire logic [7:0] flash_sr_i
);
  typedef struct packed {
    logic aw_ok;
    logic [7:0] awaddr;
    logic w_ok;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [3:0] op;
    logic go;
    logic [16:0] addr;
    logic [7:0] data;
  } fcsu_axil_t;
  fcsu_axil_t st_r;
  fcsu_axil_t st_nxt;
  logic do_wr;

  assign awready_o = !st_r.aw_ok && !st_r.bvalid;
  assign wready_o = !st_r.w_ok && !st_r.bvalid;
  assign arready_o = !st_r.rvalid;
  assign do_wr = st_r.aw_ok && st_r.w_ok && !st_r.bvalid;

  // address and data may arrive in either order; write when both held
  always_comb begin
    st_nxt = st_r;
    st_nxt.go = 1'b0;
    if (awvalid_i && awready_o) begin
      st_nxt.aw_ok = 1'b1;
      st_nxt.awaddr = awaddr_i;
    end
    if (wvalid_i && wready_o) begin
      st_nxt.w_ok = 1'b1;
      st_nxt.wdata = wdata_i;
      st_nxt.wstrb = wstrb_i;
    end
    if (do_wr) begin
      st_nxt.aw_ok = 1'b0;
      st_nxt.w_ok = 1'b0;
      st_nxt.bvalid = 1'b1;
      st_nxt.bresp = RESP_OKAY;
      case (st_r.awaddr)
        REG_CTRL: begin
          if (st_r.wstrb[0]) st_nxt.op = st_r.wdata[3:0];
          // a start while busy is dropped: the core cannot queue orders
          if (st_r.wstrb[1] && st_r.wdata[CTRL_GO] && !busy_i)
            st_nxt.go = 1'b1;
        end
        REG_ADDR: begin
          if (st_r.wstrb[0]) st_nxt.addr[7:0] = st_r.wdata[7:0];
          if (st_r.wstrb[1]) st_nxt.addr[15:8] = st_r.wdata[15:8];
          if (st_r.wstrb[2]) st_nxt.addr[16] = st_r.wdata[16];
        end
        REG_DATA: begin
          if (st_r.wstrb[0]) st_nxt.data = st_r.wdata[7:0];
        end
        REG_STAT, REG_RDATA, REG_FLASH_SR: ;
        default: st_nxt.bresp = RESP_SLVERR;
      endcase
    end
    if (st_r.bvalid && bready_i) st_nxt.bvalid = 1'b0;
    // reads answer one cycle after acceptance
    if (arvalid_i && arready_o) begin
      st_nxt.rvalid = 1'b1;
      st_nxt.rresp = RESP_OKAY;
      case (araddr_i)
        REG_CTRL: st_nxt.rdata = {23'h0, 1'b0, 4'h0, st_r.op};
        REG_ADDR: st_nxt.rdata = {15'h0, st_r.addr};
        REG_DATA: st_nxt.rdata = {24'h0, st_r.data};
        REG_STAT: st_nxt.rdata = {30'h0, refused_i, busy_i};
        REG_RDATA: st_nxt.rdata = {24'h0, rdata_i};
        REG_FLASH_SR: st_nxt.rdata = {24'h0, flash_sr_i};
        default: begin
          st_nxt.rdata = 32'h0;
          st_nxt.rresp = RESP_SLVERR;
        end
      endcase
    end else if (st_r.rvalid && rready_i) begin
      st_nxt.rvalid = 1'b0;
    end
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign bvalid_o = st_r.bvalid;
  assign bresp_o = st_r.bresp;
  assign rvalid_o = st_r.rvalid;
  assign rdata_o = st_r.rdata;
  assign rresp_o = st_r.rresp;
  assign op_o = st_r.op;
  assign go_o = st_r.go;
  assign addr_o = st_r.addr;
  assign data_o = st_r.data;
endmodule : fcsu_axil

// >>> rtl/fcsu_host.sv
// fcsu_host: host controller driving a byte-wide flash command port.
// assumes the flash samples address and data on the rising write
// strobe and answers reads within the strobe time.
// Notes on behaviour
// - status latched on later falling strobe; raise one before next read
// - host masks the three reserved low status bits; only in flash_sr, the REG_RDATA copy keeps them
// - host checks ready before trusting error bits
// - after supply-low, host clears status before program or erase; the host refuses both until a clear-status order
// - erase is setup byte then confirm, both at block address
// - while suspended only read-array, read-status and resume accepted
// - program is setup byte then address and data write
// - host writes only defined command bytes
// - write is write-enable low with chip-enable low; rising edge latches
//
// Our own choices: the register offsets and the AXI4-Lite slave port.
module fcsu_host
  import fcsu_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // axi4-lite write
  input wire logic [7:0] awaddr_i,
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] wdata_i,
  input wire logic [3:0] wstrb_i,
  input wire logic wvalid_i,
  output logic wready_o,
  output logic [1:0] bresp_o,
  output logic bvalid_o,
  input wire logic bready_i,
  // axi4-lite read
  input wire logic [7:0] araddr_i,
  input wire logic arvalid_i,
  output logic arready_o,
  output logic [31:0] rdata_o,
  output logic [1:0] rresp_o,
  output logic rvalid_o,
  input wire logic rready_i,
  // flash control pins
  output logic chip_en_n_o,
  output logic out_en_n_o,
  output logic write_en_n_o,
  output logic powerdown_reset_n_o,
  output logic [16:0] flash_addr_o,
  // flash data pins, oe low while driving
  input wire logic [7:0] flash_dq_i,
  output logic [7:0] flash_dq_o,
  output logic flash_dq_oe_n_o
);
  typedef enum {
    S_IDLE, S_CMD1, S_GAP1, S_CMD2, S_READ, S_RECOVER
  } fcsu_state_t;

  typedef struct packed {
    fcsu_state_t state;
    logic [7:0] cnt;
    logic [7:0] byte1;
    logic [7:0] byte2;
    logic two;
    logic do_read;
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic pd_n;
    logic dq_oe_n;
    logic [7:0] dq;
    logic [16:0] addr;
    logic [7:0] rdata;
    logic [7:0] flash_sr;
    logic status_mode;
    logic suspended;
    logic supply_low_seen;
    logic refused;
  } fcsu_host_t;

  fcsu_host_t st_r;
  fcsu_host_t st_nxt;
  logic [3:0] op;
  logic go;
  logic [16:0] addr;
  logic [7:0] data;
  logic [7:0] dq_sync;
  logic busy;

  assign busy = (st_r.state != S_IDLE);

  fcsu_axil u_regs (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .awaddr_i(awaddr_i),
    .awvalid_i(awvalid_i),
    .awready_o(awready_o),
    .wdata_i(wdata_i),
    .wstrb_i(wstrb_i),
    .wvalid_i(wvalid_i),
    .wready_o(wready_o),
    .bresp_o(bresp_o),
    .bvalid_o(bvalid_o),
    .bready_i(bready_i),
    .araddr_i(araddr_i),
    .arvalid_i(arvalid_i),
    .arready_o(arready_o),
    .rdata_o(rdata_o),
    .rresp_o(rresp_o),
    .rvalid_o(rvalid_o),
    .rready_i(rready_i),
    .op_o(op),
    .go_o(go),
    .addr_o(addr),
    .data_o(data),
    .busy_i(busy),
    .refused_i(st_r.refused),
    .rdata_i(st_r.rdata),
    .flash_sr_i(st_r.flash_sr)
  );

  // data pins come from another timing domain
  fcsu_sync #(.W(8)) u_dq_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .d_i(flash_dq_i),
    .q_o(dq_sync)
  );

  // order decode and pin sequencing
  always_comb begin
    st_nxt = st_r;
    case (st_r.state)
      S_IDLE: begin
        if (go) begin
          st_nxt.refused = 1'b0;
          st_nxt.addr = addr;
          st_nxt.two = 1'b0;
          st_nxt.do_read = 1'b0;
          st_nxt.state = S_CMD1;
          st_nxt.cnt = STROBE_CNT;
          case (fcsu_op_t'(op))
            OP_READ_ARRAY: st_nxt.byte1 = CMD_READ_ARRAY;
            OP_IDENT: st_nxt.byte1 = CMD_IDENT;
            OP_READ_STATUS: st_nxt.byte1 = CMD_READ_STATUS;
            OP_CLEAR_STATUS: st_nxt.byte1 = CMD_CLEAR_STATUS;
            OP_ERASE: begin
              st_nxt.byte1 = CMD_ERASE_SETUP;
              st_nxt.byte2 = CMD_CONFIRM;
              st_nxt.two = 1'b1;
            end
            OP_SUSPEND: st_nxt.byte1 = CMD_SUSPEND;
            OP_RESUME: st_nxt.byte1 = CMD_CONFIRM;
            OP_PROGRAM: begin
              st_nxt.byte1 = CMD_PROG_SETUP;
              st_nxt.byte2 = data;
              st_nxt.two = 1'b1;
            end
            OP_READ: begin
              st_nxt.do_read = 1'b1;
              st_nxt.state = S_READ;
            end
            OP_POWERDOWN: begin
              st_nxt.pd_n = 1'b0;
              st_nxt.state = S_IDLE;
            end
            OP_WAKE: begin
              st_nxt.pd_n = 1'b1;
              st_nxt.status_mode = 1'b0;
              st_nxt.suspended = 1'b0;
              st_nxt.state = S_RECOVER;
              st_nxt.cnt = RECOVER_CNT;
            end
            default: begin
              st_nxt.refused = 1'b1;
              st_nxt.state = S_IDLE;
            end
          endcase
          // after supply-low, program and erase are refused until a clear
          if ((fcsu_op_t'(op) == OP_ERASE || fcsu_op_t'(op) == OP_PROGRAM)
              && st_r.supply_low_seen) begin
            st_nxt.refused = 1'b1;
            st_nxt.state = S_IDLE;
          end
          // suspended flash takes only read-array, status, resume
          if (st_r.suspended && !(fcsu_op_t'(op) == OP_READ_ARRAY ||
              fcsu_op_t'(op) == OP_READ_STATUS ||
              fcsu_op_t'(op) == OP_RESUME || fcsu_op_t'(op) == OP_READ))
          begin
            st_nxt.refused = 1'b1;
            st_nxt.state = S_IDLE;
          end
          // a pin write to powered-down flash would be lost
          if (!st_r.pd_n && fcsu_op_t'(op) != OP_WAKE) begin
            st_nxt.refused = 1'b1;
            st_nxt.state = S_IDLE;
          end
          if (st_nxt.state == S_CMD1) begin
            st_nxt.ce_n = 1'b0;
            st_nxt.we_n = 1'b0;
            st_nxt.dq_oe_n = 1'b0;
            st_nxt.dq = st_nxt.byte1;
          end else if (st_nxt.state == S_READ) begin
            st_nxt.ce_n = 1'b0;
            st_nxt.oe_n = 1'b0;
            st_nxt.cnt = STROBE_CNT;
          end
        end
      end
      S_CMD1, S_CMD2: begin
        // rising write strobe latches address and data
        if (st_r.cnt > 8'h1) begin
          st_nxt.cnt = st_r.cnt - 8'h1;
        end else begin
          st_nxt.we_n = 1'b1;
          st_nxt.ce_n = 1'b1;
          st_nxt.cnt = RECOVER_CNT;
          st_nxt.state = (st_r.state == S_CMD1 && st_r.two) ? S_GAP1
                                                             : S_RECOVER;
          if (st_r.byte1 == CMD_READ_STATUS || st_r.two ||
              st_r.byte1 == CMD_SUSPEND || st_r.byte1 == CMD_CONFIRM)
            st_nxt.status_mode = 1'b1;
          else if (st_r.byte1 != CMD_CLEAR_STATUS)
            st_nxt.status_mode = 1'b0;
          if (st_r.byte1 == CMD_CLEAR_STATUS)
            st_nxt.supply_low_seen = 1'b0;
          if (st_r.byte1 == CMD_SUSPEND) st_nxt.suspended = 1'b1;
          if (st_r.byte1 == CMD_CONFIRM) st_nxt.suspended = 1'b0;
        end
      end
      S_GAP1: begin
        st_nxt.dq_oe_n = 1'b1;
        if (st_r.cnt > 8'h1) begin
          st_nxt.cnt = st_r.cnt - 8'h1;
        end else begin
          st_nxt.state = S_CMD2;
          st_nxt.ce_n = 1'b0;
          st_nxt.we_n = 1'b0;
          st_nxt.dq_oe_n = 1'b0;
          st_nxt.dq = st_r.byte2;
          st_nxt.cnt = STROBE_CNT;
        end
      end
      S_READ: begin
        if (st_r.cnt > 8'h1) begin
          st_nxt.cnt = st_r.cnt - 8'h1;
        end else begin
          st_nxt.rdata = dq_sync;
          if (st_r.status_mode) begin
            // reserved low bits are masked in flash_sr only; rdata keeps them
            st_nxt.flash_sr = dq_sync & SR_USED_MASK;
            if (dq_sync[SR_READY] && dq_sync[SR_SUPPLY_LOW])
              st_nxt.supply_low_seen = 1'b1;
            if (dq_sync[SR_READY] && !dq_sync[SR_SUSP])
              st_nxt.suspended = 1'b0;
          end
          // raise both strobes so the next read relatches status
          st_nxt.oe_n = 1'b1;
          st_nxt.ce_n = 1'b1;
          st_nxt.cnt = RECOVER_CNT;
          st_nxt.state = S_RECOVER;
        end
      end
      S_RECOVER: begin
        st_nxt.dq_oe_n = 1'b1;
        if (st_r.cnt > 8'h1) begin
          st_nxt.cnt = st_r.cnt - 8'h1;
        end else begin
          st_nxt.state = S_IDLE;
        end
      end
      default: st_nxt.state = S_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{state: S_IDLE, ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                pd_n: 1'b1, dq_oe_n: 1'b1, flash_sr: SR_RESET_VAL,
                default: '0};
    end else begin
      st_r <= st_nxt;
    end
  end

  assign chip_en_n_o = st_r.ce_n;
  assign out_en_n_o = st_r.oe_n;
  assign write_en_n_o = st_r.we_n;
  assign powerdown_reset_n_o = st_r.pd_n;
  assign flash_addr_o = st_r.addr;
  assign flash_dq_o = st_r.dq;
  assign flash_dq_oe_n_o = st_r.dq_oe_n;
endmodule : fcsu_host

// >>> test/fcsu_host_checker.sv
// fcsu_host_checker: pin and bus assertions for fcsu_host.
// assumes it is bound into fcsu_host; async active-high reset.
module fcsu_host_checker (
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic rst_i,
  // bus answers
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [31:0] rdata_o,
  // flash pins
  input wire logic chip_en_n_o,
  input wire logic out_en_n_o,
  input wire logic write_en_n_o,
  input wire logic powerdown_reset_n_o,
  input wire logic [16:0] flash_addr_o,
  input wire logic flash_dq_oe_n_o
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (rst_i);

  property p_we_sel;
    !write_en_n_o |-> !chip_en_n_o && !flash_dq_oe_n_o && out_en_n_o;
  endproperty
  a_we_sel: assert property (p_we_sel)
    else $error("write strobe without select or data");
  // address must not move while the strobe is low
  property p_we_hold;
    !write_en_n_o && !$past(write_en_n_o) |-> $stable(flash_addr_o);
  endproperty
  a_we_hold: assert property (p_we_hold)
    else $error("address moved inside write strobe");
  property p_we_len;
    $fell(write_en_n_o) |-> ##19 !write_en_n_o ##[1:2] write_en_n_o;
  endproperty
  a_we_len: assert property (p_we_len)
    else $error("write strobe length wrong");
  property p_rd_len;
    $fell(out_en_n_o) |-> !chip_en_n_o ##19 !out_en_n_o ##[1:2] out_en_n_o;
  endproperty
  a_rd_len: assert property (p_rd_len)
    else $error("read strobe length wrong");
  // a strobe returns high long enough before the next access
  property p_recover;
    $rose(chip_en_n_o) |-> chip_en_n_o[*8] ##1 chip_en_n_o;
  endproperty
  a_recover: assert property (p_recover)
    else $error("chip select recovery too short");
  property p_pd_quiet;
    !powerdown_reset_n_o |-> chip_en_n_o && flash_dq_oe_n_o;
  endproperty
  a_pd_quiet: assert property (p_pd_quiet)
    else $error("flash accessed in power-down");
  property p_b_hold;
    bvalid_o && !bready_i |=> bvalid_o;
  endproperty
  a_b_hold: assert property (p_b_hold)
    else $error("write response dropped");
  property p_r_hold;
    rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o);
  endproperty
  a_r_hold: assert property (p_r_hold)
    else $error("read data dropped or changed");
endmodule : fcsu_host_checker

bind fcsu_host fcsu_host_checker i_fcsu_host_checker (.ref_clk_i, .rst_i,
  .bvalid_o, .bready_i, .rvalid_o, .rready_i, .rdata_o, .chip_en_n_o,
  .out_en_n_o, .write_en_n_o, .powerdown_reset_n_o, .flash_addr_o,
  .flash_dq_oe_n_o);

// >>> test/fcsu_flash_model.sv
// fcsu_flash_model: behavioural byte-wide flash facing the host pins.
// assumes host strobes per the pin walk; clk_i paces busy time and samples the write pins.
module fcsu_flash_model
  import fcsu_pkg::*;
#(
  parameter int BUSY_CYC = 200,
  parameter logic [7:0] MFR_CODE = 8'h3a, // arbitrary value
  parameter logic [7:0] DEV_CODE = 8'h3b // arbitrary value
) (
  // pacing clock and supply level, 1 for high
  input wire logic clk_i,
  input wire logic vpp_hi_i,
  // host pins
  input wire logic ce_n_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic pd_n_i,
  input wire logic [16:0] addr_i,
  input wire logic [7:0] dq_i,
  // data towards host, a moving pattern when not read
  output logic [7:0] dq_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [0:255];
  logic [7:0] sr, sr_lat, pat, wd;
  logic [16:0] wa;
  logic [1:0] mode; // 0 array, 1 identifier, 2 status
  logic esu, psu, ers, sus, wsel;
  int cnt;

  // power-up and entry into deep power-down
  task automatic wake();
    mode = 0;
    sr = SR_RESET_VAL;
    {esu, psu, ers, sus} = 4'h0;
    cnt = 0;
  endtask : wake

  initial begin
    mem = '{default: 8'hff};
    pat = 8'h00;
    wake();
  end
  always @(negedge pd_n_i) wake();

  // capture inside the strobe; pins may move on the closing edge
  always @(posedge clk_i) begin
    pat = pat + 8'h35;
    if (!we_n_i) begin
      wsel = !ce_n_i && pd_n_i;
      wa = addr_i;
      wd = dq_i;
    end
    if (sus) sr[7:6] = 2'b11;
    else if (cnt > 1) cnt = cnt - 1;
    else if (cnt == 1) begin
      cnt = 0;
      sr[7] = 1'b1;
      if (ers) mem = '{default: 8'hff};
      ers = 1'b0;
    end
  end

  // command latch on the rising write strobe
  always @(posedge we_n_i) if (wsel) begin
    if (psu || esu) begin
      mode = 2;
      if (esu && wd != CMD_CONFIRM) sr[5:4] = 2'b11;
      else if (!vpp_hi_i) sr[3] = 1'b1;
      else begin
        if (psu) mem[wa[7:0]] = mem[wa[7:0]] & wd;
        ers = esu;
        sr[7] = 1'b0;
        cnt = BUSY_CYC;
      end
      {esu, psu} = 2'b00;
    end else if (cnt > 0 || sus) begin
      if (wd == CMD_READ_STATUS) mode = 2;
      if (wd == CMD_SUSPEND && ers) sus = 1'b1;
      if (sus && wd == CMD_READ_ARRAY) mode = 0;
      if (sus && wd == CMD_CONFIRM) begin
        sus = 1'b0;
        sr[7:6] = 2'b00;
        mode = 2;
      end
    end else begin
      case (wd)
        CMD_READ_ARRAY: mode = 0;
        CMD_IDENT: mode = 1;
        CMD_READ_STATUS: mode = 2;
        CMD_CLEAR_STATUS: sr[5:3] = 3'b000;
        CMD_ERASE_SETUP: esu = 1'b1;
        CMD_PROG_SETUP: psu = 1'b1;
        default: ;
      endcase
    end
  end

  // status held from the later falling strobe; low bits carry noise
  always @(negedge oe_n_i or negedge ce_n_i)
    if (!oe_n_i && !ce_n_i) sr_lat = sr | 8'h05;
  assign dq_o = (ce_n_i || oe_n_i || !pd_n_i) ? pat : mode == 2 ? sr_lat
    : mode == 1 ? (addr_i[0] ? DEV_CODE : MFR_CODE) : mem[addr_i[7:0]];
endmodule : fcsu_flash_model

// >>> test/test_flash_command_status_unit.sv
// test_flash_command_status_unit: self-checking bench for fcsu_host.
// assumes the behavioural flash on the pins; axi4-lite master in tasks.
module test_flash_command_status_unit
  import fcsu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MFR = 8'h3a; // arbitrary value
  localparam logic [7:0] DEV = 8'h3b; // arbitrary value
  logic clk = 0, rst = 1, vpp_hi = 1;
  logic aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
  logic [7:0] aw_a = 0, ar_a = 0, fst, hdq, mdq, dq_bus;
  logic [31:0] w_d = 0, rv, r_d;
  logic [1:0] rr, r_resp, b_resp, br;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, ce_n, oe_n, we_n, pd_n, dq_oe_n;
  logic [16:0] fa;
  int mismatches = 0;
  int num_checks = 0;

  // shared data line: host wins while it drives
  assign dq_bus = dq_oe_n ? mdq : hdq;
  always #2.5 clk = ~clk;

  fcsu_host i_fcsu_host (.ref_clk_i(clk), .rst_i(rst),
    .awaddr_i(aw_a), .awvalid_i(aw_v), .awready_o(aw_rdy), .wdata_i(w_d),
    .wstrb_i(4'hf), .wvalid_i(w_v), .wready_o(w_rdy), .bresp_o(b_resp),
    .bvalid_o(b_v), .bready_i(b_r), .araddr_i(ar_a), .arvalid_i(ar_v),
    .arready_o(ar_rdy), .rdata_o(r_d), .rresp_o(r_resp), .rvalid_o(r_v),
    .rready_i(r_r), .chip_en_n_o(ce_n), .out_en_n_o(oe_n),
    .write_en_n_o(we_n), .powerdown_reset_n_o(pd_n), .flash_addr_o(fa),
    .flash_dq_i(dq_bus), .flash_dq_o(hdq), .flash_dq_oe_n_o(dq_oe_n));
  fcsu_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV)) i_fcsu_flash_model (
    .clk_i(clk), .vpp_hi_i(vpp_hi), .ce_n_i(ce_n), .oe_n_i(oe_n),
    .we_n_i(we_n), .pd_n_i(pd_n), .addr_i(fa), .dq_i(dq_bus), .dq_o(mdq));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // ready raised late on purpose so the slave must hold its answer
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic ap, wp;
    @(posedge clk);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1;
    w_v <= 1;
    ap = 1;
    wp = 1;
    while (ap || wp) begin
      @(posedge clk);
      if (aw_rdy) ap = 0;
      if (w_rdy) wp = 0;
      aw_v <= ap;
      w_v <= wp;
    end
    repeat (2) @(posedge clk);
    b_r <= 1;
    do @(posedge clk); while (!b_v);
    br = b_resp;
    b_r <= 0;
  endtask : axw

  task automatic axr(input logic [7:0] a, output logic [31:0] d,
                     output logic [1:0] r);
    @(posedge clk);
    ar_a <= a;
    ar_v <= 1;
    do @(posedge clk); while (!ar_rdy);
    ar_v <= 0;
    repeat (2) @(posedge clk);
    r_r <= 1;
    do @(posedge clk); while (!r_v);
    d = r_d;
    r = r_resp;
    r_r <= 0;
  endtask : axr

  // issue one operation and wait until the controller is idle
  task automatic op(input logic [3:0] o, input logic [16:0] a = '0,
                    input logic [7:0] d = '0);
    axw(REG_ADDR, 32'(a));
    axw(REG_DATA, 32'(d));
    axw(REG_CTRL, 32'h100 | 32'(o));
    do axr(REG_STAT, rv, rr); while (rv[0]);
  endtask : op

  task automatic fr(input logic [16:0] a);
    op(OP_READ, a);
    axr(REG_RDATA, rv, rr);
  endtask : fr

  task automatic poll();
    op(OP_READ_STATUS);
    rv = 0;
    for (int i = 0; i < 200 && !rv[7]; i++) begin
      fr(0);
      if (i == 0) fst = rv[7:0];
    end
    rv = rv & 32'(SR_USED_MASK);
  endtask : poll

  task automatic t_regs();
    axr(REG_FLASH_SR, rv, rr);
    check(rv, 32'h80);
    axr(REG_STAT, rv, rr);
    check(rv, 32'h0);
    axr(8'h40, rv, rr);
    check(32'(rr), 32'(RESP_SLVERR));
    check(rv, 32'h0);
    // write answers: mapped word okay, unmapped word refused
    axw(REG_DATA, 32'h0);
    check(32'(br), 32'(RESP_OKAY));
    axw(8'h40, 32'h0);
    check(32'(br), 32'(RESP_SLVERR));
  endtask : t_regs

  task automatic t_ident();
    vpp_hi <= 0;
    op(OP_IDENT);
    fr(ID_MFR_ADDR);
    check(rv, 32'(MFR));
    fr(ID_DEV_ADDR);
    check(rv, 32'(DEV));
    fr(ID_MFR_ADDR);
    check(rv, 32'(MFR));
    op(OP_READ_ARRAY);
    fr(17'h00005);
    check(rv, 32'hff);
    vpp_hi <= 1;
  endtask : t_ident

  task automatic t_prog_erase();
    op(OP_PROGRAM, 17'h00005, 8'h3c);
    poll();
    check(32'(fst[7]), 32'h0);
    check(rv, 32'h80);
    op(OP_READ_ARRAY);
    fr(17'h00005);
    check(rv, 32'h3c);
    op(OP_ERASE, 17'h00005);
    fr(17'h00005);
    check(rv & 32'hf8, 32'h0);
    poll();
    check(rv, 32'h80);
    op(OP_READ_ARRAY);
    fr(17'h00005);
    check(rv, 32'hff);
  endtask : t_prog_erase

  task automatic t_suspend();
    op(OP_PROGRAM, 17'h00007, 8'h42);
    poll();
    op(OP_ERASE, 17'h00009);
    op(OP_SUSPEND);
    poll();
    check(rv, 32'hc0);
    op(OP_CLEAR_STATUS);
    axr(REG_STAT, rv, rr);
    check(rv & 32'h2, 32'h2);
    op(OP_READ_ARRAY);
    fr(17'h00007);
    check(rv, 32'h42);
    op(OP_RESUME);
    fr(0);
    check(rv & 32'hc0, 32'h0);
    poll();
    axr(REG_FLASH_SR, rv, rr);
    check(rv, 32'h80);
  endtask : t_suspend

  task automatic t_supply();
    vpp_hi <= 0;
    op(OP_PROGRAM, 17'h00003, 8'h00);
    poll();
    check(rv, 32'h88);
    op(OP_ERASE, 17'h00003);
    axr(REG_STAT, rv, rr);
    check(rv & 32'h2, 32'h2);
    op(OP_CLEAR_STATUS);
    vpp_hi <= 1;
    poll();
    check(rv, 32'h80);
    op(OP_READ_ARRAY);
    fr(17'h00003);
    check(rv, 32'hff);
  endtask : t_supply

  task automatic t_misc();
    op(4'hb);
    axr(REG_STAT, rv, rr);
    check(rv & 32'h2, 32'h2);
    op(OP_READ_STATUS);
    op(OP_POWERDOWN);
    op(OP_IDENT);
    axr(REG_STAT, rv, rr);
    check(rv & 32'h2, 32'h2);
    op(OP_WAKE);
    fr(17'h00007);
    check(rv, 32'hff);
  endtask : t_misc

  task automatic summarize();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  initial begin
    repeat (8) @(posedge clk);
    rst <= 0;
    t_regs();
    t_ident();
    t_prog_erase();
    t_suspend();
    t_supply();
    t_misc();
    summarize();
  end

  // watchdog well beyond the expected run of some three thousand cycles
  initial begin
    #400us;
    mismatches++;
    summarize();
  end
endmodule : test_flash_command_status_unit
